// ### rtl/vfsc_defines.vh
`ifndef VFSC_DEFINES_VH
`define VFSC_DEFINES_VH
// Wishbone register byte addresses
`define VFSC_ADR_CTRL 8'h00
`define VFSC_ADR_STATUS 8'h04
`define VFSC_ADR_VTIME 8'h08
`define VFSC_ADR_HTIME 8'h0C
`define VFSC_ADR_FINE 8'h10
`define VFSC_ADR_GAIN 8'h14
`define VFSC_ADR_CHROMA 8'h18
`define VFSC_ADR_PED 8'h1C
`define VFSC_ADR_HUE 8'h20
`define VFSC_ADR_PANEL 8'h24
// CTRL fields
`define VFSC_CTRL_FSYNC 0
`define VFSC_CTRL_WIDE 1
// Parameter ranges
`define VFSC_GAIN_MIN 8'h32
`define VFSC_GAIN_NOM 8'h64
`define VFSC_GAIN_MAX 8'h96
`define VFSC_PED_MIN 8'hFB
`define VFSC_PED_MAX 8'h05
`define VFSC_HUE_MIN 9'h14C
`define VFSC_HUE_MAX 9'h0B4
`define VFSC_VT_MAX 10'h270
`define VFSC_HT_MAX 12'h6B3
`define VFSC_FINE_MAX 8'hFF
// Presence codes
`define VFSC_IN_NONE 2'h0
`define VFSC_IN_525 2'h1
`define VFSC_IN_625 2'h2
// Blanking last lines
`define VFSC_BLK_N525 5'h09
`define VFSC_BLK_N625 5'h06
`define VFSC_BLK_W525 5'h14
`define VFSC_BLK_W625 5'h16
// Modes of the synchroniser
`define VFSC_MODE_PASS 2'h0
`define VFSC_MODE_TBC 2'h1
`define VFSC_MODE_LOCK 2'h2
// Timing
`define VFSC_CLK_HZ 250000000
`define VFSC_COMMIT_S 15
`define VFSC_TICK_HZ 1000
`define VFSC_TICK_DIV (`VFSC_CLK_HZ / `VFSC_TICK_HZ)
`define VFSC_COMMIT_TICKS (`VFSC_COMMIT_S * `VFSC_TICK_HZ)
`define VFSC_BLINK_TICKS 250
`define VFSC_NGROUPS 3'h3
`endif

// ### rtl/vfsc_sync2.v
`timescale 1ns/1ps
`default_nettype none
module vfsc_sync2 #(
  parameter W = 1
) (
  input wire clk_i, // Clock
  input wire rst_i, // Sync reset
  input wire [W-1:0] d_i, // Async input
  output reg [W-1:0] q_o // Synchronised
);
  reg [W-1:0] meta_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // vfsc_sync2
`default_nettype wire

// ### rtl/vfsc_divider.v
`timescale 1ns/1ps
`default_nettype none
module vfsc_divider #(
  parameter [31:0] DIV = 32'd250000
) (
  input wire clk_i, // Clock
  input wire rst_i, // Sync reset
  output reg tick_o // One-cycle pulse every DIV cycles
);
  reg [31:0] cnt_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 32'h00000000;
      tick_o <= 1'b0;
    end else if (cnt_reg == DIV - 32'd1) begin
      cnt_reg <= 32'h00000000;
      tick_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'd1;
      tick_o <= 1'b0;
    end
  end
endmodule // vfsc_divider
`default_nettype wire

// ### rtl/vfsc_top.v
// Function
// - Mode press enables editing, steps to next parameter group, wraps.
// - Arrows move selection, or raise/lower the selected parameter.
// - Edited parameter LED blinks 15 s, then value is committed.
// - Uncommitted edit is lost on power loss; stored value kept.
// - Sync on, reference present: output locked to reference, corrected.
// - Sync on, no reference: time base correction only, free running.
// - Sync off: reference ignored, output follows input, no correction.
// - Timing offsets adjustable only while frame sync is enabled.
// - Vertical offset shifts output in whole lines.
// - Horizontal offset shifts output in sample clocks.
// - Fine phase shifts output in sub-pixel steps.
// - Gain LED green when gain equals nominal.
// - Gain LED red when gain differs from nominal.
// - Both arrows together reset gain to nominal.
// - Input presence: none, 525 locked or 625 locked.
// - Reference presence: absent or present.
// - Input LED green while input detected.
// - Reference LED green while valid reference detected.
// - Overall gain spans 50 to 150 percent.
// - Chroma gain spans 50 to 150 percent.
// - Pedestal offsets black by up to plus or minus 5 IRE.
// - Hue rotates chroma by up to plus or minus 180 degrees.
// - Vertical blanking narrow or wide per standard, as selected.
`timescale 1ns/1ps
`default_nettype none
`include "vfsc_defines.vh"
module vfsc_top #(
  parameter [31:0] TICK_DIV = `VFSC_TICK_DIV,
  parameter [15:0] COMMIT_TICKS = `VFSC_COMMIT_TICKS
) (
  input wire clk_i, // 250 MHz clock
  input wire rst_i, // Sync reset, active high
  input wire [7:0] adr_i, // Wishbone byte address
  input wire [31:0] dat_i, // Wishbone write data
  output reg [31:0] dat_o, // Wishbone read data
  input wire we_i, // Wishbone write enable
  input wire [3:0] sel_i, // Wishbone byte selects
  input wire cyc_i, // Wishbone cycle
  input wire stb_i, // Wishbone strobe
  output reg ack_o, // Wishbone acknowledge
  input wire btn_mode_i, // Mode button, high pressed
  input wire btn_left_i, // Left arrow, high pressed
  input wire btn_right_i, // Right arrow, high pressed
  input wire in_lock_i, // Input detector locked
  input wire in_625_i, // Input standard is 625 lines
  input wire ref_valid_i, // Valid reference detected
  input wire [9:0] line_i, // Current output line number
  input wire [31:0] nv_gain_i, // Stored gain word
  input wire [31:0] nv_vid_i, // Stored offset word
  output reg [31:0] nv_data_o, // Word to commit
  output reg nv_wr_o, // Commit pulse
  output reg nv_sel_o, // Commit target: 0 gain, 1 offsets
  output reg [1:0] sync_mode_o, // Synchroniser mode
  output reg ref_use_o, // Genlock to reference
  output reg time_base_corrector_o, // Correction enable
  output reg [9:0] vt_o, // Vertical offset, lines
  output reg [11:0] ht_o, // Horizontal offset, sample clocks
  output reg [7:0] fine_o, // Fine phase, subpixels
  output reg [7:0] gain_o, // Gain percent
  output reg [7:0] chroma_o, // Chroma gain percent
  output reg [7:0] ped_o, // Pedestal, IRE, two's complement
  output reg [8:0] hue_o, // Hue, degrees, two's complement
  output reg vblank_o, // Output in vertical blanking
  output reg led_in_o, // Input LED green
  output reg led_ref_o, // Reference LED green
  output reg led_gain_grn_o, // Gain LED green
  output reg led_gain_red_o, // Gain LED red
  output reg [2:0] led_grp_o, // Group LEDs, blink when pending
  output reg edit_o // Panel editing active
);
  localparam [2:0] G_SYNC = 3'h0;
  localparam [2:0] G_TIME = 3'h1;
  localparam [2:0] G_GAIN = 3'h2;

  wire [4:0] pins;
  wire s_mode, s_left, s_right, s_lock, s_625;
  vfsc_sync2 #(.W(5)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({btn_mode_i, btn_left_i, btn_right_i, in_lock_i, in_625_i}),
    .q_o(pins)
  );
  assign {s_mode, s_left, s_right, s_lock, s_625} = pins;
  reg s_ref_meta, s_ref;

  wire tick;
  vfsc_divider #(.DIV(TICK_DIV)) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  // Saturating step for a 12-bit field, signed or unsigned as set by sgn
  function [11:0] step;
    input [11:0] v;
    input [11:0] lo;
    input [11:0] hi;
    input up;
    input sgn;
    reg [12:0] a;
    reg [12:0] b;
    reg [12:0] c;
    begin
      a = {v[11] & sgn, v} ^ {sgn, 12'h000};
      b = {lo[11] & sgn, lo} ^ {sgn, 12'h000};
      c = {hi[11] & sgn, hi} ^ {sgn, 12'h000};
      if (up)
        step = (a >= c) ? hi : v + 12'h001;
      else
        step = (a <= b) ? lo : v - 12'h001;
    end
  endfunction

  // Host writes land on the nearest range end, never wrap
  function [11:0] clamp;
    input [11:0] v;
    input [11:0] lo;
    input [11:0] hi;
    input sgn;
    reg [12:0] a;
    reg [12:0] b;
    reg [12:0] c;
    begin
      a = {v[11] & sgn, v} ^ {sgn, 12'h000};
      b = {lo[11] & sgn, lo} ^ {sgn, 12'h000};
      c = {hi[11] & sgn, hi} ^ {sgn, 12'h000};
      if (a > c)
        clamp = hi;
      else if (a < b)
        clamp = lo;
      else
        clamp = v;
    end
  endfunction

  reg [2:0] grp_reg;
  reg [1:0] sub_reg;
  reg sel_reg;
  reg fsync_reg, wide_reg;
  reg [2:0] mode_d, left_d, right_d;
  reg [15:0] pend_reg;
  reg pend_grp_reg;
  reg [7:0] blink_cnt;
  reg blink_reg;
  reg loaded_reg;
  wire p_mode = s_mode & ~mode_d[0];
  wire both = s_left & s_right;
  wire p_both = both & ~(left_d[0] & right_d[0]);
  wire p_left = s_left & ~left_d[0] & ~s_right;
  wire p_right = s_right & ~right_d[0] & ~s_left;
  wire wb_req = cyc_i & stb_i & ~ack_o;
  wire wb_wr = wb_req & we_i & sel_i[0];
  wire [11:0] vt_step = step({2'h0, vt_o}, 12'h000, {2'h0, `VFSC_VT_MAX},
    p_right, 1'b0);
  wire [11:0] fine_step = step({4'h0, fine_o}, 12'h000,
    {4'h0, `VFSC_FINE_MAX}, p_right, 1'b0);
  wire [11:0] gain_step = step({4'h0, gain_o}, {4'h0, `VFSC_GAIN_MIN},
    {4'h0, `VFSC_GAIN_MAX}, p_right, 1'b0);
  wire [11:0] pct_wr = clamp({4'h0, dat_i[7:0]}, {4'h0, `VFSC_GAIN_MIN},
    {4'h0, `VFSC_GAIN_MAX}, 1'b0);
  wire [11:0] ped_wr = clamp({{4{dat_i[7]}}, dat_i[7:0]},
    {4'hF, `VFSC_PED_MIN}, {4'h0, `VFSC_PED_MAX}, 1'b1);
  wire [11:0] hue_wr = clamp({{3{dat_i[8]}}, dat_i[8:0]},
    {3'h7, `VFSC_HUE_MIN}, {3'h0, `VFSC_HUE_MAX}, 1'b1);

  always @(posedge clk_i) begin
    if (rst_i) begin
      s_ref_meta <= 1'b0;
      s_ref <= 1'b0;
      mode_d <= 3'h0;
      left_d <= 3'h0;
      right_d <= 3'h0;
    end else begin
      s_ref_meta <= ref_valid_i;
      s_ref <= s_ref_meta;
      mode_d <= {mode_d[1:0], s_mode};
      left_d <= {left_d[1:0], s_left};
      right_d <= {right_d[1:0], s_right};
    end
  end

  // Settings, panel editor and commit timer
  always @(posedge clk_i) begin
    if (rst_i) begin
      grp_reg <= G_SYNC;
      sub_reg <= 2'h0;
      sel_reg <= 1'b0;
      edit_o <= 1'b0;
      fsync_reg <= 1'b1;
      wide_reg <= 1'b0;
      vt_o <= 10'h000;
      ht_o <= 12'h000;
      fine_o <= 8'h00;
      gain_o <= `VFSC_GAIN_NOM;
      chroma_o <= `VFSC_GAIN_NOM;
      ped_o <= 8'h00;
      hue_o <= 9'h000;
      pend_reg <= 16'h0000;
      pend_grp_reg <= 1'b0;
      nv_wr_o <= 1'b0;
      nv_sel_o <= 1'b0;
      nv_data_o <= 32'h00000000;
      loaded_reg <= 1'b0;
    end else begin
      nv_wr_o <= 1'b0;
      if (!loaded_reg) begin
        // Stored values are restored once after reset
        loaded_reg <= 1'b1;
        gain_o <= nv_gain_i[7:0];
        chroma_o <= nv_gain_i[15:8];
        ped_o <= nv_gain_i[23:16];
        fsync_reg <= nv_gain_i[24];
        vt_o <= nv_vid_i[9:0];
        ht_o <= nv_vid_i[21:10];
        fine_o <= nv_vid_i[29:22];
      end else begin
        if (p_mode) begin
          edit_o <= 1'b1;
          sel_reg <= 1'b0;
          sub_reg <= 2'h0;
          grp_reg <= (grp_reg == `VFSC_NGROUPS - 3'h1) ? G_SYNC
                     : grp_reg + 3'h1;
        end else if (p_both) begin
          gain_o <= `VFSC_GAIN_NOM;
          pend_reg <= COMMIT_TICKS;
          pend_grp_reg <= 1'b0;
        end else if (edit_o && grp_reg != G_SYNC && !sel_reg &&
                     (p_left || p_right)) begin
          sel_reg <= 1'b1;
          sub_reg <= p_right ? (sub_reg == 2'h2 ? 2'h0 : sub_reg + 2'h1)
                     : sub_reg;
        end else if (edit_o && (p_left || p_right)) begin
          pend_reg <= COMMIT_TICKS;
          pend_grp_reg <= (grp_reg == G_TIME);
          case (grp_reg)
            G_SYNC: fsync_reg <= p_right;
            G_TIME: if (fsync_reg) begin
              case (sub_reg)
                2'h0: vt_o <= vt_step[9:0];
                2'h1: ht_o <= step(ht_o, 12'h000, `VFSC_HT_MAX,
                  p_right, 1'b0);
                default: fine_o <= fine_step[7:0];
              endcase
            end
            G_GAIN: gain_o <= gain_step[7:0];
            default: edit_o <= 1'b0;
          endcase
        end else if (wb_wr) begin
          pend_reg <= COMMIT_TICKS;
          pend_grp_reg <= (adr_i == `VFSC_ADR_VTIME ||
            adr_i == `VFSC_ADR_HTIME || adr_i == `VFSC_ADR_FINE);
          case (adr_i)
            `VFSC_ADR_CTRL: begin
              fsync_reg <= dat_i[`VFSC_CTRL_FSYNC];
              wide_reg <= dat_i[`VFSC_CTRL_WIDE];
            end
            `VFSC_ADR_VTIME: if (fsync_reg)
              vt_o <= (dat_i[9:0] > `VFSC_VT_MAX) ? `VFSC_VT_MAX
                      : dat_i[9:0];
            `VFSC_ADR_HTIME: if (fsync_reg)
              ht_o <= (dat_i[11:0] > `VFSC_HT_MAX) ? `VFSC_HT_MAX
                      : dat_i[11:0];
            `VFSC_ADR_FINE: if (fsync_reg) fine_o <= dat_i[7:0];
            `VFSC_ADR_GAIN: gain_o <= pct_wr[7:0];
            `VFSC_ADR_CHROMA: chroma_o <= pct_wr[7:0];
            `VFSC_ADR_PED: ped_o <= ped_wr[7:0];
            `VFSC_ADR_HUE: hue_o <= hue_wr[8:0];
            default: pend_reg <= pend_reg;
          endcase
        end else if (tick && pend_reg != 16'h0000) begin
          pend_reg <= pend_reg - 16'h0001;
          if (pend_reg == 16'h0001) begin
            // Only this pulse writes storage; a power loss sooner keeps old
            nv_wr_o <= 1'b1;
            nv_sel_o <= pend_grp_reg;
            nv_data_o <= pend_grp_reg ? {2'h0, fine_o, ht_o, vt_o}
                         : {7'h00, fsync_reg, ped_o, chroma_o, gain_o};
          end
        end
      end
    end
  end

  // Blink clock for pending LEDs
  always @(posedge clk_i) begin
    if (rst_i) begin
      blink_cnt <= 8'h00;
      blink_reg <= 1'b0;
    end else if (tick) begin
      if (blink_cnt == `VFSC_BLINK_TICKS - 1) begin
        blink_cnt <= 8'h00;
        blink_reg <= ~blink_reg;
      end else begin
        blink_cnt <= blink_cnt + 8'h01;
      end
    end
  end

  // Mode decode, status LEDs and blanking
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_mode_o <= `VFSC_MODE_PASS;
      ref_use_o <= 1'b0;
      time_base_corrector_o <= 1'b0;
      led_in_o <= 1'b0;
      led_ref_o <= 1'b0;
      led_gain_grn_o <= 1'b0;
      led_gain_red_o <= 1'b0;
      led_grp_o <= 3'h0;
      vblank_o <= 1'b0;
    end else begin
      if (fsync_reg && s_ref) begin
        sync_mode_o <= `VFSC_MODE_LOCK;
        ref_use_o <= 1'b1;
        time_base_corrector_o <= 1'b1;
      end else if (fsync_reg) begin
        sync_mode_o <= `VFSC_MODE_TBC;
        ref_use_o <= 1'b0;
        time_base_corrector_o <= 1'b1;
      end else begin
        sync_mode_o <= `VFSC_MODE_PASS;
        ref_use_o <= 1'b0;
        time_base_corrector_o <= 1'b0;
      end
      led_in_o <= s_lock;
      led_ref_o <= s_ref;
      led_gain_grn_o <= (gain_o == `VFSC_GAIN_NOM);
      led_gain_red_o <= (gain_o != `VFSC_GAIN_NOM);
      led_grp_o <= (edit_o ? (3'h1 << grp_reg) : 3'h0)
        ^ ((pend_reg != 16'h0000 && blink_reg) ?
           (pend_grp_reg ? 3'h2 : 3'h5) : 3'h0);
      if (s_625)
        vblank_o <= line_i >= 10'h001 && line_i <= {5'h00,
          wide_reg ? `VFSC_BLK_W625 : `VFSC_BLK_N625};
      else
        vblank_o <= line_i >= 10'h001 && line_i <= {5'h00,
          wide_reg ? `VFSC_BLK_W525 : `VFSC_BLK_N525};
    end
  end

  // Wishbone slave, registered single-cycle ack, one wait state
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= wb_req;
      if (wb_req && !we_i) begin
        case (adr_i)
          `VFSC_ADR_CTRL: dat_o <= {30'h0, wide_reg, fsync_reg};
          `VFSC_ADR_STATUS: dat_o <= {28'h0, s_ref,
            1'b0, !s_lock ? `VFSC_IN_NONE
            : (s_625 ? `VFSC_IN_625 : `VFSC_IN_525)};
          `VFSC_ADR_VTIME: dat_o <= {22'h0, vt_o};
          `VFSC_ADR_HTIME: dat_o <= {20'h0, ht_o};
          `VFSC_ADR_FINE: dat_o <= {24'h0, fine_o};
          `VFSC_ADR_GAIN: dat_o <= {24'h0, gain_o};
          `VFSC_ADR_CHROMA: dat_o <= {24'h0, chroma_o};
          `VFSC_ADR_PED: dat_o <= {24'h0, ped_o};
          `VFSC_ADR_HUE: dat_o <= {23'h0, hue_o};
          `VFSC_ADR_PANEL: dat_o <= {8'h00, pend_reg, sub_reg,
            sel_reg, edit_o, 1'b0, grp_reg};
          default: dat_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // vfsc_top
`default_nettype wire

// ### sim/vfsc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module vfsc_top_assertions (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic cyc_i, // Cycle
  input wire logic stb_i, // Strobe
  input wire logic ack_o, // Ack
  input wire logic in_lock_i, // Input lock
  input wire logic ref_valid_i, // Reference seen
  input wire logic nv_wr_o, // Commit
  input wire logic [1:0] sync_mode_o, // Mode
  input wire logic ref_use_o, // Genlock
  input wire logic time_base_corrector_o, // Correction
  input wire logic [7:0] gain_o, // Gain
  input wire logic [7:0] chroma_o, // Chroma
  input wire logic [7:0] ped_o, // Pedestal
  input wire logic [8:0] hue_o, // Hue
  input wire logic led_in_o, // Input LED
  input wire logic led_ref_o, // Ref LED
  input wire logic led_gain_grn_o, // Green
  input wire logic led_gain_red_o // Red
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence gain_nom_held;
    (gain_o == 8'h64)[*3];
  endsequence
  sequence gain_off_held;
    (gain_o != 8'h64)[*3];
  endsequence
  bus_ack_a: assert property (bus_req |=> ack_o ##1 !ack_o)
    else $error("bus ack not a single cycle pulse");
  mode_lock_a: assert property (sync_mode_o == 2'h2 |->
    ref_use_o && time_base_corrector_o) else $error("locked mode wrong");
  mode_tbc_a: assert property (sync_mode_o == 2'h1 |->
    !ref_use_o && time_base_corrector_o) else $error("tbc mode wrong");
  mode_pass_a: assert property (sync_mode_o == 2'h0 |->
    !ref_use_o && !time_base_corrector_o) else $error("pass mode wrong");
  gain_green_a: assert property (gain_nom_held |->
    led_gain_grn_o && !led_gain_red_o) else $error("gain led not green");
  gain_red_a: assert property (gain_off_held |->
    led_gain_red_o && !led_gain_grn_o) else $error("gain led not red");
  gain_range_a: assert property (gain_o >= 8'h32 && gain_o <= 8'h96)
    else $error("gain out of range");
  chroma_range_a: assert property (chroma_o >= 8'h32 &&
    chroma_o <= 8'h96) else $error("chroma out of range");
  ped_range_a: assert property ($signed(ped_o) >= -5 &&
    $signed(ped_o) <= 5) else $error("pedestal out of range");
  hue_range_a: assert property ($signed(hue_o) >= -180 &&
    $signed(hue_o) <= 180) else $error("hue out of range");
  input_led_a: assert property ($stable(in_lock_i)[*5] |->
    led_in_o == in_lock_i) else $error("input led wrong");
  ref_led_a: assert property ($stable(ref_valid_i)[*5] |->
    led_ref_o == ref_valid_i) else $error("ref led wrong");
  commit_pulse_a: assert property (nv_wr_o |=> !nv_wr_o)
    else $error("commit pulse too long");
endmodule // vfsc_top_assertions
`default_nettype wire

// ### sim/vfsc_video_src.sv
`timescale 1ns/1ps
`default_nettype none
module vfsc_video_src (
  input wire logic clk_i, // Clock
  input wire logic [1:0] std_i, // 0 none, 1 525, 2 625
  input wire logic ref_i, // Reference connected
  input wire logic [9:0] line_i, // Line to present
  output logic in_lock_o, // Input locked
  output logic in_625_o, // 625-line input
  output logic ref_valid_o, // Reference valid
  output logic [9:0] line_o // Output line
);
  logic [9:0] wander;
  initial begin
    wander = 10'h000;
    {in_lock_o, in_625_o, ref_valid_o, line_o} = 13'h0000;
  end
  always @(posedge clk_i) begin
    wander <= wander + 10'h001;
    in_lock_o <= std_i != 2'h0;
    ref_valid_o <= ref_i;
    // Without input neither standard nor line count can be trusted
    in_625_o <= (std_i != 2'h0) ? std_i == 2'h2 : wander[0];
    line_o <= (std_i != 2'h0) ? line_i : ~wander;
  end
endmodule // vfsc_video_src
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "vfsc_defines.vh"
module tb;
  logic clk_i, rst_i, we_i, cyc_i, stb_i, bm, bl, br, ref_on, ack_o;
  logic lock, s625, refv, nv_wr_o, nv_sel_o, ref_use, time_base_corrector, vblank_o;
  logic led_in, led_ref, grn, red, edit_o;
  logic [1:0] std, sync_mode_o;
  logic [2:0] grp_led;
  logic [3:0] sel_i;
  logic [7:0] adr_i, fine_o, gain_o, chroma_o, ped_o;
  logic [8:0] hue_o;
  logic [9:0] line_set, line, vt_o;
  logic [11:0] ht_o;
  logic [31:0] dat_i, dat_o, nv_data_o, q;
  int errors = 0;
  int checks_done = 0;
  vfsc_video_src vfsc_video_src_inst (.clk_i(clk_i), .std_i(std),
    .ref_i(ref_on), .line_i(line_set), .in_lock_o(lock), .in_625_o(s625),
    .ref_valid_o(refv), .line_o(line));
  vfsc_top #(.TICK_DIV(32'd4), .COMMIT_TICKS(16'd5)) vfsc_top_inst (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .btn_mode_i(bm), .btn_left_i(bl),
    .btn_right_i(br), .in_lock_i(lock), .in_625_i(s625),
    .ref_valid_i(refv), .line_i(line), .nv_gain_i(32'h0100_6464),
    .nv_vid_i(32'h0000_0000), .nv_data_o(nv_data_o), .nv_wr_o(nv_wr_o),
    .nv_sel_o(nv_sel_o), .sync_mode_o(sync_mode_o), .ref_use_o(ref_use),
    .time_base_corrector_o(time_base_corrector), .vt_o(vt_o), .ht_o(ht_o),
    .fine_o(fine_o), .gain_o(gain_o), .chroma_o(chroma_o), .ped_o(ped_o),
    .hue_o(hue_o), .vblank_o(vblank_o), .led_in_o(led_in),
    .led_ref_o(led_ref), .led_gain_grn_o(grn), .led_gain_red_o(red),
    .led_grp_o(grp_led), .edit_o(edit_o));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Request held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    if (k == 20) begin
      errors++;
      summarize();
    end
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
  endtask
  task automatic press(input logic [2:0] b);
    {bm, bl, br} <= b;
    cyc(6);
    {bm, bl, br} <= 3'h0;
    cyc(6);
  endtask
  task automatic t_modes;
    wb(1, `VFSC_ADR_CTRL, 1);
    ref_on <= 1;
    cyc(8);
    chk("mode", `VFSC_MODE_LOCK, sync_mode_o);
    chk("ref led", 1, led_ref);
    wb(0, `VFSC_ADR_STATUS, 0);
    chk("ref status", 1, q[3]);
    ref_on <= 0;
    cyc(8);
    chk("mode", `VFSC_MODE_TBC, sync_mode_o);
    chk("correction", 1, time_base_corrector);
    wb(1, `VFSC_ADR_CTRL, 0);
    ref_on <= 1;
    cyc(8);
    chk("mode", `VFSC_MODE_PASS, sync_mode_o);
    chk("ref use", 0, ref_use);
  endtask
  task automatic t_offsets;
    wb(1, `VFSC_ADR_VTIME, 5);
    chk("vt locked", 0, vt_o);
    wb(1, `VFSC_ADR_CTRL, 1);
    wb(1, `VFSC_ADR_VTIME, 32'h270);
    wb(1, `VFSC_ADR_HTIME, 32'hFFF);
    wb(1, `VFSC_ADR_FINE, 32'h80);
    cyc(2);
    chk("vt", 10'h270, vt_o);
    chk("ht", `VFSC_HT_MAX, ht_o);
    chk("fine", 8'h80, fine_o);
  endtask
  task automatic t_proc;
    wb(1, `VFSC_ADR_GAIN, 32'hFF);
    cyc(4);
    chk("gain", `VFSC_GAIN_MAX, gain_o);
    chk("red", 1, red);
    wb(1, `VFSC_ADR_GAIN, 32'h10);
    wb(1, `VFSC_ADR_CHROMA, 32'h20);
    wb(1, `VFSC_ADR_PED, 32'hFFFF_FFFA);
    wb(1, `VFSC_ADR_HUE, 32'hFFFF_FF4B);
    cyc(2);
    chk("gain", `VFSC_GAIN_MIN, gain_o);
    chk("chroma", `VFSC_GAIN_MIN, chroma_o);
    chk("ped", `VFSC_PED_MIN, ped_o);
    chk("hue", `VFSC_HUE_MIN, hue_o);
    wb(0, 8'h28, 0);
    chk("unmapped", 0, q);
  endtask
  task automatic t_both;
    int k;
    press(3'h3);
    chk("gain", `VFSC_GAIN_NOM, gain_o);
    chk("green", 1, grn);
    for (k = 0; k < 200 && nv_wr_o !== 1'b1; k++) @(posedge clk_i);
    chk("commit", 1, nv_wr_o);
    chk("commit word", {1'b0, 8'h64}, {nv_sel_o, nv_data_o[7:0]});
  endtask
  task automatic t_panel;
    logic [2:0] g;
    logic [7:0] old;
    int k;
    press(3'h4);
    chk("edit", 1, edit_o);
    chk("group led", 3'h2, grp_led);
    wb(0, `VFSC_ADR_PANEL, 0);
    g = q[2:0];
    repeat (3) press(3'h4);
    wb(0, `VFSC_ADR_PANEL, 0);
    chk("group wrap", g, q[2:0]);
    for (k = 0; k < 3 && q[2:0] !== 3'h2; k++) begin
      press(3'h4);
      wb(0, `VFSC_ADR_PANEL, 0);
    end
    old = gain_o;
    press(3'h1);
    chk("gain select", old, gain_o);
    press(3'h1);
    chk("gain up", 1, gain_o > old);
    press(3'h2);
    chk("gain down", old, gain_o);
  endtask
  task automatic t_status;
    logic [9:0] lt [8] = '{9, 10, 20, 21, 6, 7, 22, 23};
    int i;
    for (i = 0; i < 3; i++) begin
      std <= i[1:0];
      cyc(8);
      wb(0, `VFSC_ADR_STATUS, 0);
      chk("input status", i[1:0], q[1:0]);
      chk("input led", i != 0, led_in);
    end
    for (i = 0; i < 8; i++) begin
      std <= (i < 4) ? 2'h1 : 2'h2;
      line_set <= lt[i];
      wb(1, `VFSC_ADR_CTRL, {30'h0, i[1], 1'b1});
      cyc(6);
      chk("vblank", !i[0], vblank_o);
    end
  endtask
  task automatic t_powerloss;
    int k, seen;
    seen = 0;
    wb(1, `VFSC_ADR_GAIN, 32'h70);
    rst_i <= 1;
    cyc(6);
    rst_i <= 0;
    for (k = 0; k < 100; k++) begin
      @(negedge clk_i);
      if (nv_wr_o === 1'b1) seen++;
    end
    chk("lost commit", 0, seen);
    chk("stored gain", `VFSC_GAIN_NOM, gain_o);
  endtask
  initial begin
    {rst_i, we_i, cyc_i, stb_i, bm, bl, br, ref_on} = 8'h80;
    {std, sel_i, adr_i, dat_i, line_set} = {2'h1, 4'hF, 50'h0};
    cyc(6);
    rst_i <= 0;
    cyc(3);
    chk("reset gain", `VFSC_GAIN_NOM, gain_o);
    t_modes();
    t_offsets();
    t_proc();
    t_both();
    t_panel();
    t_status();
    t_powerloss();
    summarize();
  end
endmodule // tb
bind vfsc_top vfsc_top_assertions vfsc_top_assertions_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .ack_o(ack_o), .in_lock_i(in_lock_i), .ref_valid_i(ref_valid_i),
  .nv_wr_o(nv_wr_o), .sync_mode_o(sync_mode_o), .ref_use_o(ref_use_o),
  .time_base_corrector_o(time_base_corrector_o), .gain_o(gain_o),
  .chroma_o(chroma_o), .ped_o(ped_o), .hue_o(hue_o), .led_in_o(led_in_o),
  .led_ref_o(led_ref_o), .led_gain_grn_o(led_gain_grn_o),
  .led_gain_red_o(led_gain_red_o));
`default_nettype wire
